// File: wdwt_consts.svh
/*
 * timing constants and field layout for the watchdog and wake timing block.
 * assumes core_clk at 20 MHz; slow rc tick derived by a divider.
 */
`ifndef WDWT_CONSTS_SVH
`define WDWT_CONSTS_SVH
`define WDWT_CLK_HZ          20000000
`define WDWT_SLOW_RC_HZ      31000
`define WDWT_SLOW_DIV        (`WDWT_CLK_HZ / `WDWT_SLOW_RC_HZ)
`define WDWT_PRE5_DIV        32
`define WDWT_PRE7_DIV        128
`define WDWT_POST_MAX_CODE   4'hf
`define WDWT_VREG_US         10
`define WDWT_POWER_UP_DELAY_TIMER_MS         64
`define WDWT_WAKE_SLOW_US    190
`define WDWT_WAKE_FAST_US    25
`define WDWT_WAKE_NOSTBY_US  9
`define WDWT_WAKE_FAST_CODE  2'h1
`define WDWT_CYC_US(us)      (((us) * (`WDWT_CLK_HZ / 1000000)))
`endif

// File: wdwt_pkg.sv
/*
 * types shared by the watchdog and wake timing block.
 * assumes nothing beyond a systemverilog compiler.
 */
package wdwt_pkg;
    // two-bit run state, usual path run -> low power -> wake -> run; wake to run flips both bits
    typedef enum logic [1:0]
    {
        WDWT_RUN   = 2'b00,
        WDWT_LOWPW = 2'b01,
        WDWT_WAKE  = 2'b11,
        WDWT_START = 2'b10
    } wdwt_state_t;
endpackage : wdwt_pkg

// File: wdwt_delay.sv
/*
 * loadable down counter used for start and wake delays.
 * assumes a synchronous load strobe and core clock domain.
 */
`timescale 1ns/1ps
module wdwt_delay
#(
    parameter int W = 24
)
(
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic         load,
    input  wire logic [W-1:0] count,
    output logic              busy
);
    logic [W-1:0] cnt_q;

    // -----------------------------------------------------------------
    // countdown
    // -----------------------------------------------------------------
    // load wins over counting so a retrigger restarts the full delay
    always_ff @(posedge core_clk)
    begin
        if (rst)
            cnt_q <= '0;
        else if (load)
            cnt_q <= count;
        else if (cnt_q != '0)
            cnt_q <= cnt_q - 1'b1;
    end

    assign busy = (cnt_q != '0);
endmodule // wdwt_delay

// File: wdwt_top.sv
/*
 * watchdog with prescaler and postscaler, plus regulator start,
 * power-up and standby wake delays.
 * assumes instruction, reset and clock-switch events are one-cycle
 * pulses synchronous to core_clk.
 */
// What this block does
// - watchdog counts slow rc ticks; enabling watchdog enables oscillator
// - prescale select picks divide by 32 or divide by 128
// - prescaler period alone is about 1 ms or 4 ms
// - four-bit postscale field gives sixteen ratios 1:1 to 1:32768
// - device reset or clock switch completion clears all counts
// - entering and leaving sleep or idle clears all counts
// - clear watchdog instruction clears counter, prescaler and postscaler
// - watchdog runs in low power; timeout wakes, resume after instr
// - timeout flag set and held until software clears it
// - regulator on: hold execution 10 us after reset or idle wake; sleep wake uses standby wake time
// - regulator off: 64 ms power-up delay after power-on or brown-out
// - sleep puts regulator in standby unless standby disable is set
// - standby wake 190 us default; select code 01 gives 25 us
// - standby disabled keeps flash powered; wake under 10 us
// - regulator off wake uses regulator delay; standby disable shortens
`timescale 1ns/1ps
`include "wdwt_consts.svh"
module wdwt_top
#(
    parameter int POWER_UP_DELAY_TIMER_CYC = `WDWT_POWER_UP_DELAY_TIMER_MS * 20000,
    parameter int SLOW_DIV = `WDWT_SLOW_DIV
)
(
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              wdog_enable,
    input  wire logic              wdog_prescale_select,
    input  wire logic [3:0]        wdog_postscale_select,
    input  wire logic              clear_wdog_instr,
    input  wire logic              power_save_instr,
    input  wire logic              power_save_idle,
    input  wire logic              wake_event,
    input  wire logic              osc_switch_done,
    input  wire logic              por_bor_reset,
    input  wire logic              regulator_enable,
    input  wire logic              regulator_standby_disable,
    input  wire logic [1:0]        regulator_wake_time_select,
    input  wire logic              wdog_flag_clear,
    input  wire logic              sleep_flag_clear,
    input  wire logic              idle_flag_clear,
    output logic                   slow_rc_oscillator,
    output logic                   wdog_timeout_flag,
    output logic                   sleep_flag,
    output logic                   idle_flag,
    output logic                   regulator_standby,
    output logic                   flash_powered,
    output logic                   exec_hold,
    output wdwt_pkg::wdwt_state_t  run_state
);
    import wdwt_pkg::*;

    // all checks below sample on the core clock and sleep through reset
    default clocking chk_cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    localparam int DW = 24;
    localparam logic [DW-1:0] VREG_CYC = DW'(`WDWT_CYC_US(`WDWT_VREG_US));
    localparam logic [DW-1:0] SLOW_CYC = DW'(`WDWT_CYC_US(`WDWT_WAKE_SLOW_US));
    localparam logic [DW-1:0] FAST_CYC = DW'(`WDWT_CYC_US(`WDWT_WAKE_FAST_US));
    localparam logic [DW-1:0] NOSB_CYC =
        DW'(`WDWT_CYC_US(`WDWT_WAKE_NOSTBY_US));

    wdwt_state_t   state_q;
    logic [15:0]   rc_div_q;
    logic          rc_tick;
    logic [6:0]    pre_q;
    logic          pre_tick;
    logic [14:0]   post_q;
    logic          timeout;
    logic          wdog_clear;
    logic          wake_go;
    logic          delay_load;
    logic [DW-1:0] delay_cnt;
    logic          delay_busy;
    logic          por_q;

    // -----------------------------------------------------------------
    // slow rc tick
    // -----------------------------------------------------------------
    // oscillator runs whenever the watchdog is enabled
    assign slow_rc_oscillator = wdog_enable;

    // divider stands in for the slow rc oscillator
    always_ff @(posedge core_clk)
    begin
        if (rst || !wdog_enable || rc_tick)
            rc_div_q <= '0;
        else
            rc_div_q <= rc_div_q + 16'h0001;
    end
    // gated so no stray tick leaks out in the cycle the watchdog turns off
    assign rc_tick = wdog_enable && (rc_div_q == 16'(SLOW_DIV - 1));

    // -----------------------------------------------------------------
    // count clears
    // -----------------------------------------------------------------
    // leaving low power goes through the wake state
    assign wake_go = (state_q == WDWT_LOWPW) && (wake_event || timeout);
    assign wdog_clear = rst || osc_switch_done
                      || power_save_instr || wake_go
                      || (clear_wdog_instr && state_q == WDWT_RUN);

    // -----------------------------------------------------------------
    // prescaler and postscaler
    // -----------------------------------------------------------------
    // 32 or 128 slow ticks per prescaler period
    always_ff @(posedge core_clk)
    begin
        if (wdog_clear || pre_tick)
            pre_q <= '0;
        else if (rc_tick)
            pre_q <= pre_q + 7'h01;
    end
    assign pre_tick = rc_tick && (wdog_prescale_select
        ? (pre_q == 7'(`WDWT_PRE7_DIV - 1))
        : (pre_q == 7'(`WDWT_PRE5_DIV - 1)));

    // postscaler ratio is two to the power of the code
    always_ff @(posedge core_clk)
    begin
        if (wdog_clear || timeout)
            post_q <= '0;
        else if (pre_tick)
            post_q <= post_q + 15'h0001;
    end
    // timeout counts in every state, low power too
    assign timeout = wdog_enable && pre_tick
        && (post_q == 15'((32'h1 << wdog_postscale_select) - 1));

    // -----------------------------------------------------------------
    // status flags
    // -----------------------------------------------------------------
    // set wins over a clear in the same cycle
    always_ff @(posedge core_clk)
    begin
        if (rst)
            wdog_timeout_flag <= 1'b0;
        else if (timeout)
            wdog_timeout_flag <= 1'b1;
        else if (wdog_flag_clear)
            wdog_timeout_flag <= 1'b0;
    end

    // hardware never clears these on wake; software must
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            sleep_flag <= 1'b0;
            idle_flag  <= 1'b0;
        end
        else
        begin
            if (power_save_instr && !power_save_idle)
                sleep_flag <= 1'b1;
            else if (sleep_flag_clear)
                sleep_flag <= 1'b0;
            if (power_save_instr && power_save_idle)
                idle_flag <= 1'b1;
            else if (idle_flag_clear)
                idle_flag <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // run state
    // -----------------------------------------------------------------
    // power-on marker caught during reset, a clocked strap
    always_ff @(posedge core_clk)
    begin
        if (rst)
            por_q <= 1'b1;
        else if (state_q == WDWT_START)
            por_q <= 1'b0;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            state_q <= WDWT_START;
        else
        begin
            case (state_q)
                WDWT_START:
                    if (!delay_busy && !delay_load)
                        state_q <= WDWT_RUN;
                WDWT_RUN:
                    if (power_save_instr)
                        state_q <= WDWT_LOWPW;
                WDWT_LOWPW:
                    if (wake_go)
                        state_q <= WDWT_WAKE;
                WDWT_WAKE:
                    if (!delay_busy && !delay_load)
                        state_q <= WDWT_RUN;
                default:
                    state_q <= WDWT_RUN;
            endcase
        end
    end
    assign run_state = state_q;

    // -----------------------------------------------------------------
    // start and wake delays
    // -----------------------------------------------------------------
    assign delay_load = (state_q == WDWT_START && por_q)
                     || wake_go;

    // pick the delay for this resume
    always_comb
    begin
        delay_cnt = VREG_CYC;
        if (state_q == WDWT_START)
        begin
            if (!regulator_enable && por_bor_reset)
                delay_cnt = DW'(POWER_UP_DELAY_TIMER_CYC);
        end
        else if (sleep_flag && regulator_standby_disable)
            delay_cnt = NOSB_CYC;
        else if (sleep_flag && regulator_enable)
            delay_cnt = (regulator_wake_time_select == `WDWT_WAKE_FAST_CODE)
                      ? FAST_CYC : SLOW_CYC;
    end

    wdwt_delay #(.W(DW)) u_delay
    (
        .core_clk (core_clk),
        .rst      (rst),
        .load     (delay_load),
        .count    (delay_cnt),
        .busy     (delay_busy)
    );

    // execution held while any delay runs or in low power
    assign exec_hold = (state_q != WDWT_RUN);

    // regulator standby only in sleep, unless disabled
    assign regulator_standby = (state_q == WDWT_LOWPW) && sleep_flag
                            && !regulator_standby_disable;
    assign flash_powered = !regulator_standby;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    sequence enter_low_s;
        state_q == WDWT_RUN && power_save_instr;
    endsequence

    flag_sticky_a: assert property (
        timeout |=> wdog_timeout_flag)
        else $error("timeout flag not set");
    flag_hold_a: assert property (
        wdog_timeout_flag && !wdog_flag_clear |=> wdog_timeout_flag)
        else $error("timeout flag dropped");
    clr_instr_a: assert property (
        clear_wdog_instr && state_q == WDWT_RUN |=> post_q == 0 && pre_q == 0)
        else $error("clear instr did not clear");
    swc_clear_a: assert property (
        osc_switch_done |=> post_q == 0 && pre_q == 0)
        else $error("clock switch did not clear");
    enter_low_a: assert property (
        enter_low_s |=> state_q == WDWT_LOWPW && pre_q == 0)
        else $error("low power entry wrong");
    wake_clear_a: assert property (
        wake_go |=> post_q == 0 && pre_q == 0)
        else $error("wake did not clear counts");
    wake_timeout_a: assert property (
        state_q == WDWT_LOWPW && timeout |=> state_q == WDWT_WAKE)
        else $error("timeout did not wake");
    standby_gate_a: assert property (
        regulator_standby |-> !regulator_standby_disable && sleep_flag)
        else $error("standby while disabled");
    wake_fast_a: assert property (
        wake_go && sleep_flag && regulator_enable && !regulator_standby_disable
        && regulator_wake_time_select == 2'h1 |=> delay_busy [*8])
        else $error("fast wake too short");
    pre_div_a: assert property (
        pre_tick && !wdog_prescale_select |-> pre_q == 7'h1f)
        else $error("prescale 32 wrong");
    osc_en_a: assert property (
        rc_tick |-> slow_rc_oscillator)
        else $error("tick without oscillator");
endmodule // wdwt_top

// File: wdwt_tb.sv
/*
 * self-checking bench for the watchdog and wake timing block.
 * assumes wdwt_top built with short slow tick and power-up counts.
 */
`timescale 1ns/1ps
module testbench;
    import wdwt_pkg::*;
    logic core_clk = 1'b0, rst = 1'b1, wdog_enable = 1'b1;
    logic wdog_prescale_select = 1'b0, clear_wdog_instr = 1'b0;
    logic [3:0] wdog_postscale_select = 4'h0;
    logic power_save_instr = 1'b0, power_save_idle = 1'b0;
    logic wake_event = 1'b0, osc_switch_done = 1'b0, por_bor_reset = 1'b0;
    logic regulator_enable = 1'b1, regulator_standby_disable = 1'b0;
    logic [1:0] regulator_wake_time_select = 2'h0;
    logic wdog_flag_clear = 1'b0, sleep_flag_clear = 1'b0;
    logic idle_flag_clear = 1'b0;
    logic slow_rc_oscillator, wdog_timeout_flag, sleep_flag, idle_flag;
    logic regulator_standby, flash_powered, exec_hold;
    wdwt_state_t run_state;
    int failures = 0;
    int checks_done = 0;
    int cyc = 0;
    int n;

    // short counts: one slow tick is 2 clocks, power-up delay 50 clocks
    wdwt_top #(.POWER_UP_DELAY_TIMER_CYC(50), .SLOW_DIV(2)) dut (.core_clk, .rst,
        .wdog_enable, .wdog_prescale_select, .wdog_postscale_select,
        .clear_wdog_instr, .power_save_instr, .power_save_idle, .wake_event,
        .osc_switch_done, .por_bor_reset, .regulator_enable,
        .regulator_standby_disable, .regulator_wake_time_select,
        .wdog_flag_clear, .sleep_flag_clear, .idle_flag_clear,
        .slow_rc_oscillator, .wdog_timeout_flag, .sleep_flag, .idle_flag,
        .regulator_standby, .flash_powered, .exec_hold, .run_state);

    // ----------------------------------------
    // clock, hang guard and report
    // ----------------------------------------
    always #25 core_clk = ~core_clk;

    // ceiling well above the ~6.5k cycles the sequence needs
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ----------------------------------------
    // access and compare tasks
    // ----------------------------------------
    // inputs move 2 ns after the edge so the dut samples settled values
    task automatic step(input int k);
        repeat (k) @(posedge core_clk);
        #2;
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp_state(input wdwt_state_t got, input wdwt_state_t exp);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic in_win(input int k, input int lo, input int hi);
        cmp_bit(k >= lo && k <= hi, 1'b1);
    endtask

    task automatic wait_state(input wdwt_state_t st, input int lim,
                              output int k);
        k = 0;
        while (run_state !== st && k < lim)
        begin
            step(1);
            k++;
        end
    endtask

    // clear flag and counts, then count clocks to the next timeout
    task automatic meas_to(input logic pre, input logic [3:0] code,
                           input int exp);
        wdog_prescale_select = pre;
        wdog_postscale_select = code;
        wdog_flag_clear = 1'b1;
        clear_wdog_instr = 1'b1;
        step(1);
        wdog_flag_clear = 1'b0;
        clear_wdog_instr = 1'b0;
        n = 0;
        while (wdog_timeout_flag !== 1'b1 && n < exp + 20)
        begin
            step(1);
            n++;
        end
        in_win(n, exp - 4, exp + 4);
    endtask

    // enter low power, wake by watchdog or event, time the wake delay
    task automatic do_sleep(input logic idle, input logic [1:0] sel,
                            input logic sbd, input logic evt, input int exp);
        power_save_idle = idle;
        regulator_wake_time_select = sel;
        regulator_standby_disable = sbd;
        wdog_prescale_select = 1'b0;
        wdog_postscale_select = evt ? 4'hf : 4'h0;
        wdog_flag_clear = 1'b1;
        power_save_instr = 1'b1;
        step(1);
        wdog_flag_clear = 1'b0;
        power_save_instr = 1'b0;
        cmp_state(run_state, WDWT_LOWPW);
        cmp_bit(regulator_standby, !idle && !sbd);
        cmp_bit(flash_powered, idle || sbd);
        cmp_bit(exec_hold, 1'b1);
        if (evt)
        begin
            step(10);
            wake_event = 1'b1;
            step(1);
            wake_event = 1'b0;
        end
        wait_state(WDWT_WAKE, 300, n);
        if (!evt)
        begin
            in_win(n, 58, 68);
            cmp_bit(wdog_timeout_flag, 1'b1);
        end
        wait_state(WDWT_RUN, 4000, n);
        if (exp > 0)
            in_win(n, exp - 5, exp + 5);
        cmp_bit(idle ? idle_flag : sleep_flag, 1'b1);
        sleep_flag_clear = 1'b1;
        idle_flag_clear = 1'b1;
        step(1);
        sleep_flag_clear = 1'b0;
        idle_flag_clear = 1'b0;
        cmp_bit(sleep_flag | idle_flag, 1'b0);
    endtask

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial
    begin
        step(16);
        cmp_bit(exec_hold, 1'b1);
        rst = 1'b0;
        wait_state(WDWT_RUN, 400, n);
        in_win(n, 195, 206);
        // regulator off after power-on: power-up delay instead
        regulator_enable = 1'b0;
        por_bor_reset = 1'b1;
        rst = 1'b1;
        step(16);
        rst = 1'b0;
        wait_state(WDWT_RUN, 400, n);
        in_win(n, 45, 56);
        regulator_enable = 1'b1;
        por_bor_reset = 1'b0;
        cmp_bit(slow_rc_oscillator, 1'b1);
        meas_to(1'b0, 4'h0, 64);
        cmp_bit(wdog_timeout_flag, 1'b1);
        step(30);
        cmp_bit(wdog_timeout_flag, 1'b1);
        meas_to(1'b1, 4'h0, 256);
        meas_to(1'b0, 4'h3, 512);
        // restarts every 41 clocks keep a 64-clock timeout away
        wdog_postscale_select = 4'h0;
        for (int i = 0; i < 6; i++)
        begin
            clear_wdog_instr = !i[0];
            osc_switch_done = i[0];
            wdog_flag_clear = 1'b1;
            step(1);
            clear_wdog_instr = 1'b0;
            osc_switch_done = 1'b0;
            wdog_flag_clear = 1'b0;
            step(40);
            cmp_bit(wdog_timeout_flag, 1'b0);
        end
        do_sleep(1'b0, 2'h0, 1'b0, 1'b0, 3800);
        do_sleep(1'b0, 2'h1, 1'b0, 1'b1, 500);
        do_sleep(1'b0, 2'h0, 1'b1, 1'b1, 180);
        do_sleep(1'b1, 2'h0, 1'b0, 1'b1, 200);
        // regulator off: sleep wake falls back to the regulator delay
        regulator_enable = 1'b0;
        do_sleep(1'b0, 2'h0, 1'b0, 1'b1, 200);
        regulator_enable = 1'b1;
        // disabled watchdog must not time out even at the shortest ratio
        wdog_enable = 1'b0;
        wdog_postscale_select = 4'h0;
        wdog_flag_clear = 1'b1;
        step(1);
        wdog_flag_clear = 1'b0;
        cmp_bit(slow_rc_oscillator, 1'b0);
        step(100);
        cmp_bit(wdog_timeout_flag, 1'b0);
        results();
    end
endmodule // testbench
